//--- pkg/acr_pkg.sv
// Register map, field positions, reset values and types of the converter.
`default_nettype none
package acr_pkg;
    // Byte addresses of the word-aligned registers.
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_CS_TWO = 8'h04;
    localparam logic [7:0] ADDR_CS_ONE = 8'h08;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_RES_LOW = 8'h10;
    localparam logic [7:0] ADDR_CMP_HIGH = 8'h14;
    localparam logic [7:0] ADDR_CMP_LOW = 8'h18;
    localparam logic [7:0] ADDR_PIN_ONE = 8'h1C;
    localparam logic [7:0] ADDR_PIN_TWO = 8'h20;
    localparam logic [7:0] ADDR_POWER = 8'h24;
    // Field positions.
    localparam int CFG_LOWPWR_BIT = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LSMP_BIT = 4;
    localparam int CFG_RES_LSB = 2;
    localparam int CFG_CLK_LSB = 0;
    localparam int CS2_ACT_BIT = 7;
    localparam int CS2_HWTRG_BIT = 6;
    localparam int CS2_CMPEN_BIT = 5;
    localparam int CS2_CMPGT_BIT = 4;
    localparam int CS1_CONV_COMPLETE_FLAG_BIT = 7;
    localparam int CS1_COMPLETE_IRQ_ENABLE_BIT = 6;
    localparam int CS1_CONT_BIT = 5;
    // Field codes.
    localparam logic [1:0] RES_TEN_BIT = 2'h2;
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    localparam logic [4:0] CHAN_OFF = 5'h1F;
    // Reset values.
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_CS_TWO = 8'h00;
    localparam logic [7:0] RST_CS_ONE = 8'h1F;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Writable masks: control/status two keeps bits 3:0 at zero.
    localparam logic [7:0] CS2_WMASK = 8'h70;
    localparam logic [7:0] CS1_WMASK = 8'h7F;
    // Power modes.
    typedef enum logic [1:0]
    {
        PM_RUN = 2'b00,
        PM_STOP3 = 2'b01,
        PM_STOP12 = 2'b10
    } acr_pmode_e;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } acr_state_e;
    // Request to and answer from the analog core.
    typedef struct packed
    {
        logic start;
        logic abort;
        logic [4:0] channel;
    } acr_core_req_s;
    typedef struct packed
    {
        logic done;
        logic [9:0] data;
    } acr_core_ans_s;
endpackage
`default_nettype wire

//--- logic/acr_ctrl.sv
// Register file and sequencing control of the approximation converter.
//
// Operation
// - Stop3 without asynchronous clock aborts the conversion and idles.
// - Stop3 entry or exit never changes the result registers.
// - After a stop3 abort a new trigger is needed to restart.
// - With the asynchronous clock, the converter keeps running in stop3.
// - With the async clock, a running conversion completes in stop3.
// - In stop3 with the async clock, hardware trigger or continuous mode start new conversions.
// - A completion in stop3 sets the flag and may raise a wake request.
// - Entering stop1 or stop2 disables the converter.
// - After stop1 or stop2 every register but power mode holds its reset value.
// - Config holds low power, divider, long sample, resolution, clock.
// - Divider 00 is one, resolution 10 is ten bits, clock 00 bus.
// - Control two holds active flag, trigger, compare enable, direction.
// - Control two bits 3:2 read zero and bits 1:0 stay zero.
// - Control one holds flag, irq enable, continuous, channel select.
// - Compare value registers hold the value used when comparing.
// - Pin control bits disable digital I/O of matching analog pins.
// - Writing control one restarts conversion unless hardware trigger is selected, channel is all ones, or stop1, stop2 or stop3 without async clock holds it idle.
// - In ten-bit mode, between high and low reads, no result lands.
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_trigger,
    output acr_pkg::acr_core_req_s core_req,
    input wire acr_pkg::acr_core_ans_s core_ans,
    output logic [15:0] pin_disable,
    output logic [1:0] clock_divide_select,
    output logic low_power_select,
    output logic long_sample_select,
    output logic [1:0] input_clock_select,
    output logic irq
);
    // Registers.
    logic [7:0] converter_config, next_converter_config;
    logic [7:0] control_status_two, next_control_status_two;
    logic [7:0] control_status_one, next_control_status_one;
    logic [9:0] result, next_result;
    logic [7:0] compare_value_high, next_compare_value_high;
    logic [7:0] compare_value_low, next_compare_value_low;
    logic [7:0] pin_control_one, next_pin_control_one;
    logic [7:0] pin_control_two, next_pin_control_two;
    logic [1:0] pmode, next_pmode;
    logic block, next_block;
    logic trig_q1, trig_q2, trig_q3;
    acr_pkg::acr_state_e state, next_state;
    logic start_now, abort_now;

    // Bus decode: zero-wait slave, errors on unmapped addresses.
    logic wr, rd, hit;
    logic [7:0] wbyte;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign hit = (paddr <= acr_pkg::ADDR_POWER) && (paddr[1:0] == 2'b00);
    assign pslverr = psel && penable && !hit;

    // Field views of the configuration and control registers.
    logic stop3, stop12, async_sel, ten_bit, cont_sel, hw_sel, cmp_en, cmp_gt;
    logic [4:0] channel_select;
    assign stop3 = (pmode == acr_pkg::PM_STOP3);
    assign stop12 = (pmode == acr_pkg::PM_STOP12);
    assign input_clock_select = converter_config[acr_pkg::CFG_CLK_LSB +: 2];
    assign async_sel = (input_clock_select == acr_pkg::CLK_ASYNC);
    assign ten_bit = converter_config[acr_pkg::CFG_RES_LSB +: 2]
        == acr_pkg::RES_TEN_BIT;
    assign clock_divide_select = converter_config[acr_pkg::CFG_DIV_LSB +: 2];
    assign low_power_select = converter_config[acr_pkg::CFG_LOWPWR_BIT];
    assign long_sample_select = converter_config[acr_pkg::CFG_LSMP_BIT];
    assign hw_sel = control_status_two[acr_pkg::CS2_HWTRG_BIT];
    assign cmp_en = control_status_two[acr_pkg::CS2_CMPEN_BIT];
    assign cmp_gt = control_status_two[acr_pkg::CS2_CMPGT_BIT];
    assign cont_sel = control_status_one[acr_pkg::CS1_CONT_BIT];
    assign channel_select = control_status_one[4:0];

    // Hardware trigger comes from a pin: synchronise, then detect a rise.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_q1 <= 1'b0;
            trig_q2 <= 1'b0;
            trig_q3 <= 1'b0;
        end
        else
        begin
            trig_q1 <= hw_trigger;
            trig_q2 <= trig_q1;
            trig_q3 <= trig_q2;
        end
    end
    logic trig_rise;
    assign trig_rise = trig_q2 && !trig_q3;

    // Compare arithmetic: result plus two's complement of the compare value.
    logic [9:0] cmp_val, diff;
    logic cmp_true;
    assign cmp_val = {compare_value_high[1:0], compare_value_low};
    assign diff = 10'(core_ans.data - cmp_val);
    assign cmp_true = cmp_gt ? (core_ans.data >= cmp_val)
                             : (core_ans.data < cmp_val);

    // Sequencer: aborts on mode writes or stop, starts on triggers.
    logic cfg_write, cs1_write, done_ok, stop3_abort;
    assign cs1_write = wr && paddr == acr_pkg::ADDR_CS_ONE;
    assign cfg_write = wr && (paddr == acr_pkg::ADDR_CONFIG
        || paddr == acr_pkg::ADDR_CS_TWO || paddr == acr_pkg::ADDR_CMP_HIGH
        || paddr == acr_pkg::ADDR_CMP_LOW);
    assign stop3_abort = stop3 && !async_sel;
    assign done_ok = state == acr_pkg::ST_CONV && core_ans.done;
    always_comb
    begin
        next_state = state;
        start_now = 1'b0;
        abort_now = 1'b0;
        if (stop12 || stop3_abort || cfg_write)
        begin
            // Idle, and wait for a fresh trigger afterwards.
            abort_now = (state == acr_pkg::ST_CONV);
            next_state = acr_pkg::ST_IDLE;
        end
        else if (cs1_write)
        begin
            abort_now = (state == acr_pkg::ST_CONV);
            start_now = !hw_sel && wbyte[4:0] != acr_pkg::CHAN_OFF;
            next_state = start_now ? acr_pkg::ST_CONV : acr_pkg::ST_IDLE;
        end
        else if (state == acr_pkg::ST_IDLE)
        begin
            // Hardware trigger keeps working in stop3 with the async clock.
            start_now = hw_sel && trig_rise
                && channel_select != acr_pkg::CHAN_OFF;
            next_state = start_now ? acr_pkg::ST_CONV : acr_pkg::ST_IDLE;
        end
        else if (done_ok)
        begin
            // Continuous mode, or a blocked transfer, restarts at once.
            start_now = cont_sel || (block && ten_bit
                && !(cmp_en && !cmp_true));
            next_state = start_now ? acr_pkg::ST_CONV : acr_pkg::ST_IDLE;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= acr_pkg::ST_IDLE;
        else
            state <= next_state;
    end
    assign core_req.start = start_now;
    assign core_req.abort = abort_now;
    assign core_req.channel = channel_select;

    // Result transfer, completion flag and read blocking.
    logic transfer;
    assign transfer = done_ok && !(block && ten_bit)
        && !(cmp_en && !cmp_true);

    // Register file next values; stop1/stop2 forces all but the power mode to reset.
    always_comb
    begin
        next_converter_config = converter_config;
        next_control_status_two = control_status_two;
        next_control_status_one = control_status_one;
        next_result = result;
        next_compare_value_high = compare_value_high;
        next_compare_value_low = compare_value_low;
        next_pin_control_one = pin_control_one;
        next_pin_control_two = pin_control_two;
        next_block = block;
        next_pmode = pmode;
        // Power mode is written from the system power controller.
        if (wr && paddr == acr_pkg::ADDR_POWER)
            next_pmode = wbyte[1:0];
        if (wr)
        begin
            case (paddr)
                acr_pkg::ADDR_CONFIG:
                    next_converter_config = wbyte;
                acr_pkg::ADDR_CS_TWO: next_control_status_two =
                    wbyte & acr_pkg::CS2_WMASK;
                acr_pkg::ADDR_CS_ONE:
                begin
                    // Writing control one clears the completion flag.
                    next_control_status_one = wbyte & acr_pkg::CS1_WMASK;
                end
                acr_pkg::ADDR_CMP_HIGH: next_compare_value_high = wbyte;
                acr_pkg::ADDR_CMP_LOW: next_compare_value_low = wbyte;
                acr_pkg::ADDR_PIN_ONE: next_pin_control_one = wbyte;
                acr_pkg::ADDR_PIN_TWO: next_pin_control_two = wbyte;
                default: next_block = block;
            endcase
        end
        // Reading the high byte arms blocking, reading the low byte frees it.
        if (rd && paddr == acr_pkg::ADDR_RES_HIGH)
            next_block = 1'b1;
        if (rd && paddr == acr_pkg::ADDR_RES_LOW)
            next_block = 1'b0;
        // Reading the low byte also clears the flag; a new transfer wins.
        if (rd && paddr == acr_pkg::ADDR_RES_LOW)
            next_control_status_one[acr_pkg::CS1_CONV_COMPLETE_FLAG_BIT] = 1'b0;
        // The result only moves on a completed transfer or on a stop1/stop2 reset.
        if (transfer)
        begin
            next_result = cmp_en ? diff : core_ans.data;
            next_control_status_one[acr_pkg::CS1_CONV_COMPLETE_FLAG_BIT] = 1'b1;
        end
        if (stop12)
        begin
            next_converter_config = acr_pkg::RST_CONFIG;
            next_control_status_two = acr_pkg::RST_CS_TWO;
            next_control_status_one = acr_pkg::RST_CS_ONE;
            next_result = 10'h000;
            next_compare_value_high = acr_pkg::RST_BYTE;
            next_compare_value_low = acr_pkg::RST_BYTE;
            next_pin_control_one = acr_pkg::RST_BYTE;
            next_pin_control_two = acr_pkg::RST_BYTE;
            next_block = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_config <= acr_pkg::RST_CONFIG;
            control_status_two <= acr_pkg::RST_CS_TWO;
            control_status_one <= acr_pkg::RST_CS_ONE;
            result <= 10'h000;
            compare_value_high <= acr_pkg::RST_BYTE;
            compare_value_low <= acr_pkg::RST_BYTE;
            pin_control_one <= acr_pkg::RST_BYTE;
            pin_control_two <= acr_pkg::RST_BYTE;
            block <= 1'b0;
            pmode <= acr_pkg::PM_RUN;
        end
        else
        begin
            converter_config <= next_converter_config;
            control_status_two <= next_control_status_two;
            control_status_one <= next_control_status_one;
            result <= next_result;
            compare_value_high <= next_compare_value_high;
            compare_value_low <= next_compare_value_low;
            pin_control_one <= next_pin_control_one;
            pin_control_two <= next_pin_control_two;
            block <= next_block;
            pmode <= next_pmode;
        end
    end

    // Pin disables follow the pin control bits directly.
    assign pin_disable = {pin_control_two, pin_control_one};
    // Level interrupt, which also serves as the stop3 wake request.
    assign irq = control_status_one[acr_pkg::CS1_CONV_COMPLETE_FLAG_BIT]
        && control_status_one[acr_pkg::CS1_COMPLETE_IRQ_ENABLE_BIT];

    // Read mux; the active flag is live state, reserved bits read zero.
    logic [7:0] rbyte;
    always_comb
    begin
        case (paddr)
            acr_pkg::ADDR_CONFIG: rbyte = converter_config;
            acr_pkg::ADDR_CS_TWO: rbyte = control_status_two
                | {state == acr_pkg::ST_CONV, 7'h00};
            acr_pkg::ADDR_CS_ONE: rbyte = control_status_one;
            acr_pkg::ADDR_RES_HIGH: rbyte = {6'h00, result[9:8]};
            acr_pkg::ADDR_RES_LOW: rbyte = result[7:0];
            acr_pkg::ADDR_CMP_HIGH: rbyte = compare_value_high;
            acr_pkg::ADDR_CMP_LOW: rbyte = compare_value_low;
            acr_pkg::ADDR_PIN_ONE: rbyte = pin_control_one;
            acr_pkg::ADDR_PIN_TWO: rbyte = pin_control_two;
            acr_pkg::ADDR_POWER: rbyte = {6'h00, pmode};
            default: rbyte = 8'h00;
        endcase
    end
    assign prdata = {24'h000000, rbyte};

    // Checks.
    a_stop3_abort: assert property (@(posedge pclk)
        disable iff (!presetn)
        stop3_abort |=> state == acr_pkg::ST_IDLE)
        else $error("stop3 did not idle the converter");
    a_result_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        !transfer && !stop12 |=> $stable(result))
        else $error("result changed without a transfer");
    a_no_self_resume: assert property (@(posedge pclk)
        disable iff (!presetn)
        state == acr_pkg::ST_IDLE && !cs1_write && !(hw_sel && trig_rise)
        |=> state == acr_pkg::ST_IDLE)
        else $error("converter resumed without trigger");
    a_async_runs: assert property (@(posedge pclk)
        disable iff (!presetn)
        stop3 && async_sel && state == acr_pkg::ST_CONV && !core_ans.done
        && !cfg_write && !cs1_write |=> state == acr_pkg::ST_CONV)
        else $error("conversion lost in stop3 with async clock");
    a_flag_set: assert property (@(posedge pclk)
        disable iff (!presetn)
        transfer && !stop12 |=> control_status_one[7])
        else $error("completion flag not set");
    // The wake request must follow a completion when the enable is set.
    a_irq_wake: assert property (@(posedge pclk)
        disable iff (!presetn)
        transfer && !stop12 && !cs1_write
        && control_status_one[acr_pkg::CS1_COMPLETE_IRQ_ENABLE_BIT] |=> irq)
        else $error("completion did not raise the wake request");
    a_stop12_reset: assert property (@(posedge pclk)
        disable iff (!presetn)
        stop12 |=> converter_config == 8'h00 && pin_control_one == 8'h00
        && state == acr_pkg::ST_IDLE)
        else $error("registers not reset in stop1 or stop2");
    a_cs2_low_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        control_status_two[3:0] == 4'h0)
        else $error("control two low bits not zero");
    a_block_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        block && ten_bit && done_ok |=> $stable(result))
        else $error("result transferred while blocked");
    // A high byte read must arm blocking, or the pair could tear.
    a_block_arm: assert property (@(posedge pclk)
        disable iff (!presetn)
        rd && paddr == acr_pkg::ADDR_RES_HIGH && !stop12 |=> block)
        else $error("high byte read did not arm blocking");
    a_irq_level: assert property (@(posedge pclk)
        disable iff (!presetn)
        irq == (control_status_one[7] && control_status_one[6]))
        else $error("interrupt does not follow flag and enable");
    a_cs1_start: assert property (@(posedge pclk)
        disable iff (!presetn)
        cs1_write && !hw_sel && !stop12 && !stop3_abort && !cfg_write
        && wbyte[4:0] != 5'h1F |-> core_req.start)
        else $error("control one write did not start");
endmodule // acr_ctrl
`default_nettype wire

//--- test/test_adc_lowpower_regs_control.sv
// Self-checking testbench of the converter control with a register model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; \
    if ((got) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module test_adc_lowpower_regs_control;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, hw_trigger = 0, low_power_select;
    logic long_sample_select, irq;
    logic [1:0] clock_divide_select, input_clock_select;
    logic [15:0] pin_disable;
    acr_pkg::acr_core_req_s core_req;
    acr_pkg::acr_core_ans_s core_ans = '0;
    int n_fail = 0, compares = 0, n_start = 0, n_abort = 0, s, a;
    // Register model: bytes by word index, result, flags and blocking.
    logic [7:0] m [0:9];
    logic [9:0] mres;
    logic mflag, mact, mblk;
    logic [7:0] d;
    acr_ctrl acr_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_trigger(hw_trigger), .core_req(core_req), .core_ans(core_ans),
        .pin_disable(pin_disable), .clock_divide_select(clock_divide_select),
        .low_power_select(low_power_select), .irq(irq),
        .long_sample_select(long_sample_select),
        .input_clock_select(input_clock_select));
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    // Start and abort are one-cycle pulses, so they are counted at each edge.
    always @(posedge pclk)
    begin
        if (core_req.start === 1'b1) n_start++;
        if (core_req.abort === 1'b1) n_abort++;
    end
    task automatic mreset();
        foreach (m[i]) m[i] = 8'h00;
        m[2] = 8'h1F;
        mres = 10'h0;
        {mflag, mact, mblk} = 3'b000;
    endtask
    // One APB transfer; data and error are taken at the edge with ready high.
    // Only the watchdog ends a slave that never answers.
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [7:0] wd);
        logic rdy;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            rdy = pready;
            r = prdata;
            e = pslverr;
        end while (rdy !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(negedge pclk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        apb(1, ad, wd);
        case (ad)
            8'h00: begin m[0] = wd; mact = 0; end
            8'h04: begin m[1] = wd & 8'h70; mact = 0; end
            8'h08: begin m[2] = wd & 8'h7F; mflag = 0;
                mact = (wd[4:0] != 5'h1F) && !m[1][6]; end
            8'h24: begin m[9] = wd;
                if (wd == 8'h02) mreset();
                if (wd == 8'h01 && m[0][1:0] != 2'h3) mact = 0; end
            8'h14, 8'h18: begin m[ad >> 2] = wd; mact = 0; end
            // Pin control writes are not a mode change and leave it running.
            default: m[ad >> 2] = wd;
        endcase
    endtask
    task automatic rd(input logic [7:0] ad);
        logic [7:0] ex;
        case (ad)
            8'h04: ex = {mact, m[1][6:0]};
            8'h08: ex = {mflag, m[2][6:0]};
            8'h0C: ex = {6'h0, mres[9:8]};
            8'h10: ex = mres[7:0];
            default: ex = m[ad >> 2];
        endcase
        apb(0, ad, 8'h00);
        `CHK("read data", ex, r[7:0])
        if (ad == 8'h0C && m[0][3:2] == 2'h2) mblk = 1;
        if (ad == 8'h10) begin mblk = 0; mflag = 0; end
    endtask
    // The core answers once; a blocked result restarts the converter if the compare passes.
    // A failed compare drops the result; continuous mode always goes on.
    task automatic fin(input logic [9:0] dv);
        logic [9:0] cv;
        logic ok;
        cv = {m[5][1:0], m[6]};
        ok = !m[1][5] || (m[1][4] ? dv >= cv : dv < cv);
        @(posedge pclk);
        core_ans <= {1'b1, dv};
        @(posedge pclk);
        core_ans <= {1'b0, ~dv};
        @(negedge pclk);
        if (ok && !mblk)
        begin
            mres = m[1][5] ? 10'(dv - cv) : dv;
            mflag = 1;
        end
        mact = m[2][5] || (mblk && ok);
        `CHK("irq", mflag & m[2][6], irq)
    endtask
    task automatic hwp();
        @(posedge pclk);
        hw_trigger <= 1;
        repeat (6) @(posedge pclk);
        hw_trigger <= 0;
        @(negedge pclk);
        mact = 1;
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #160000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        s = $urandom(55524);
        mreset();
        repeat (6) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 9; i++) rd(8'(i * 4));
        apb(0, 8'h3C, 8'h00);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            d = (i == 4) ? 8'h98 : 8'($urandom);
            wr(8'h00, d);
            `CHK("fields", d, {low_power_select, clock_divide_select,
                long_sample_select, m[0][3:2], input_clock_select})
        end
        `CHK("div one", 2'h0, clock_divide_select)
        `CHK("bus clock", acr_pkg::CLK_BUS, input_clock_select)
        wr(8'h04, 8'h0F);
        rd(8'h04);
        wr(8'h04, 8'h00);
        s = n_start;
        wr(8'h08, 8'h41);
        `CHK("start", s + 1, n_start)
        `CHK("channel", 5'h01, core_req.channel)
        rd(8'h04);
        wr(8'h1C, 8'h02);
        `CHK("pin one", 16'h0002, pin_disable)
        wr(8'h14, 8'($urandom) & 8'h03);
        wr(8'h18, 8'($urandom));
        rd(8'h14);
        rd(8'h18);
        $display("test init done");
        wr(8'h08, 8'h41);
        fin(10'($urandom));
        rd(8'h08);
        rd(8'h0C);
        rd(8'h10);
        wr(8'h08, 8'h41);
        rd(8'h0C);
        fin(10'($urandom));
        rd(8'h08);
        rd(8'h10);
        $display("test blocking done");
        wr(8'h08, 8'h41);
        a = n_abort;
        wr(8'h24, 8'h01);
        // The abort pulse follows one cycle after the mode write lands.
        @(negedge pclk);
        `CHK("stop abort", a + 1, n_abort)
        rd(8'h0C);
        s = n_start;
        wr(8'h24, 8'h00);
        repeat (20) @(posedge pclk);
        `CHK("no resume", s, n_start)
        rd(8'h10);
        rd(8'h04);
        $display("test stop3 bus clock done");
        wr(8'h00, 8'h9B);
        wr(8'h04, 8'h40);
        wr(8'h08, 8'h41);
        s = n_start;
        hwp();
        `CHK("hw start", s + 1, n_start)
        a = n_abort;
        wr(8'h24, 8'h01);
        @(negedge pclk);
        `CHK("keep running", a, n_abort)
        fin(10'($urandom));
        `CHK("wake", 1'b1, irq)
        rd(8'h08);
        s = n_start;
        hwp();
        `CHK("stop3 start", s + 1, n_start)
        fin(10'($urandom));
        wr(8'h24, 8'h00);
        rd(8'h0C);
        $display("test stop3 async done");
        wr(8'h24, 8'h02);
        for (int i = 0; i < 3; i++) rd(8'(i * 4));
        `CHK("pins reset", 16'h0000, pin_disable)
        `CHK("irq reset", 1'b0, irq)
        wr(8'h24, 8'h00);
        rd(8'h08);
        $display("test stop1 done");
        // Continuous compare in stop3 on the async clock.
        wr(8'h00, 8'h9B);
        wr(8'h14, 8'h01);
        wr(8'h18, 8'h00);
        wr(8'h04, 8'h30);
        wr(8'h08, 8'h21);
        rd(8'h10);
        wr(8'h24, 8'h01);
        fin(10'h0FF);
        rd(8'h08);
        fin(10'($urandom) | 10'h100);
        rd(8'h04);
        rd(8'h0C);
        rd(8'h10);
        $display("test compare done");
        end_sim();
    end
endmodule // test_adc_lowpower_regs_control
`default_nettype wire
